// ===== dsc_ctrl.sv
// Purpose: DPLL state sequencing, lock flags and DCO numerator steering
// Assumes: Detectors and pins feed in; software uses APB with no waits
// Notes:   Read data is captured in the setup cycle and shown in access
//
// What this block does
// - Free-run after start-up once crystal valid
// - Free-run reports every reference unqualified
// - Lost reference with history on but not valid goes free-run
// - Any valid reference starts lock acquisition
// - Fast acquire widens bandwidth during acquisition
// - Lock loss flags as bits and pins
// - History accumulates after frequency lock if enabled
// - Lost reference enters holdover when applicable
// - History off uses signed free-run offset
// - History on uses averaged data once valid
// - Holdover sets phase flag, freezes frequency flag
// - Valid input during holdover restarts locking
// - Soft resets rerun start-up and calibration
// - Steer digital numerator closed-loop, else analog
// - Steering enable accepted while locked
// - 38-bit step word added or subtracted
// - Step write: zero raises, one lowers
// - Trigger pin rising edge steps, direction pin
// - Clearing enable drops accumulated digital offset; analog offset kept
// - Absolute numerator write; zero denominator is 2^40
// - Analog offset relative or direct; report numerator
// - Relative analog offset fed by size, period
`timescale 1ns/1ns
module dsc_ctrl #(
  parameter int NUM_REFS = 2
) (
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [7:0]                      paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire dsc_pkg::dsc_det_t               det,
  input  wire logic [NUM_REFS-1:0]             ref_valid,
  input  wire logic [dsc_pkg::GPIO_N-1:0]      gpio_in,
  output dsc_pkg::dsc_mode_t                   mode,
  output logic [NUM_REFS-1:0]                  ref_qualified,
  output logic                                 wide_bw,
  output logic                                 freq_lock_loss_flag,
  output logic                                 phase_lock_loss_flag,
  output logic [1:0]                           status_pin,
  output logic                                 hist_accum_en,
  output logic                                 use_history,
  output logic [dsc_pkg::NUM_W-1:0]            holdover_offset_word,
  output logic [dsc_pkg::NUM_W-1:0]            dpll_num_eff,
  output logic [dsc_pkg::NUM_W:0]              dpll_den_eff,
  output logic [dsc_pkg::NUM_W-1:0]            effective_analog_numerator,
  output logic                                 vco_cal_start,
  output logic                                 steer_active
);
  localparam int W = dsc_pkg::NUM_W;

  if (NUM_REFS < 1 || NUM_REFS > 32 || dsc_pkg::PULSE_MIN_CYC < 1) begin : g_chk
    $error("dsc_ctrl: unsupported parameter");
  end

  dsc_pkg::dsc_state_t st_r;
  dsc_pkg::dsc_state_t st_nxt;

  // Status pin source: lock flags, history activity or ramp done
  function automatic logic stat_mux(input logic [1:0] sel,
                                    input logic       f,
                                    input logic       p,
                                    input logic       h,
                                    input logic       r);
    logic v;
    v = f;
    unique case (sel)
      2'd0: v = f;
      2'd1: v = p;
      2'd2: v = h;
      2'd3: v = r;
    endcase
    return v;
  endfunction

  logic            wr;
  logic            rd_setup;
  logic            any_ref;
  logic            hist_en;
  logic            hold_ok;
  logic            closed;
  logic            rst_wr;
  logic            sw_step;
  logic            trig_rise;
  logic            pin_dir;
  logic            step_go;
  logic            step_dn;
  logic            hacc;
  logic [W-1:0]    step_ext;
  logic [W-1:0]    mag;
  logic [W-1:0]    ramp_sz;
  logic [W-1:0]    delta;
  logic [W-1:0]    free_new;
  logic            map_ok;
  logic [1:0]      trig_sel;
  logic [1:0]      dir_sel;
  logic [dsc_pkg::GPIO_N-1:0] lvl_new;

  // Bus decode
  assign wr       = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign map_ok   = (paddr[1:0] == 2'b00) && (paddr <= dsc_pkg::A_AEFF_HI);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~map_ok;
  assign prdata   = st_r.rdata;

  assign any_ref  = |ref_valid;
  assign hist_en  = st_r.ctrl[dsc_pkg::C_HIST_EN];
  assign hold_ok  = ~hist_en | det.hist_valid;
  assign closed   = (st_r.mode == dsc_pkg::ST_ACQ) ||
                    (st_r.mode == dsc_pkg::ST_LOCKED);
  assign rst_wr   = wr && paddr == dsc_pkg::A_CTRL &&
                    (pwdata[dsc_pkg::C_DEV_RST] | pwdata[dsc_pkg::C_PLL_RST]);
  assign trig_sel = st_r.ctrl[dsc_pkg::C_TRIG_LSB +: dsc_pkg::GPIO_W];
  assign dir_sel  = st_r.ctrl[dsc_pkg::C_DIR_LSB +: dsc_pkg::GPIO_W];
  assign hacc     = hist_en & ~st_r.fll & (st_r.mode == dsc_pkg::ST_LOCKED);

  // Pin level moves once stages two and three agree
  for (genvar g = 0; g < dsc_pkg::GPIO_N; g++) begin : g_lvl
    assign lvl_new[g] = (st_r.s2[g] == st_r.s3[g]) ? st_r.s3[g] : st_r.lvl[g];
  end

  // Step requests from software write or trigger pin
  assign sw_step   = wr && paddr == dsc_pkg::A_STEP;
  assign trig_rise = lvl_new[trig_sel] & ~st_r.lvl[trig_sel];
  assign pin_dir   = st_r.lvl[dir_sel];
  assign step_go   = sw_step | (st_r.ctrl[dsc_pkg::C_PINMODE] & trig_rise);
  assign step_dn   = sw_step ? pwdata[0] : pin_dir;
  assign step_ext  = {{(W-dsc_pkg::STEP_W){1'b0}}, st_r.step_word};

  // Ramp step: the smaller of the programmed size and what remains
  assign ramp_sz = {{(W-16){1'b0}}, st_r.ramp_cfg[15:0]};
  assign mag     = st_r.ramp_rem[W-1] ? W'(-st_r.ramp_rem) : st_r.ramp_rem;
  always_comb begin
    delta = (mag < ramp_sz) ? mag : ramp_sz;
    if (st_r.ramp_rem[W-1]) begin
      delta = W'(-delta);
    end
  end
  assign free_new = (paddr == dsc_pkg::A_FREE_LO) ?
                    {st_r.free_word[W-1:32], pwdata} :
                    {pwdata[W-33:0], st_r.free_word[31:0]};

  // Next state of the whole block
  always_comb begin
    st_nxt = st_r;
    st_nxt.cal_start = 1'b0;
    // Three-stage pin synchroniser; a level counts when stages agree
    st_nxt.s1 = gpio_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.lvl = lvl_new;
    // Register writes
    if (wr) begin
      unique case (paddr)
        dsc_pkg::A_CTRL:     st_nxt.ctrl = pwdata &
                                 ~(32'h0000_0001 << dsc_pkg::C_DEV_RST) &
                                 ~(32'h0000_0001 << dsc_pkg::C_PLL_RST);
        dsc_pkg::A_SWORD_LO: st_nxt.step_word[31:0] = pwdata;
        dsc_pkg::A_SWORD_HI: st_nxt.step_word[37:32] = pwdata[5:0];
        dsc_pkg::A_FBNUM_LO: st_nxt.fb_num[31:0] = pwdata;
        dsc_pkg::A_FBNUM_HI: st_nxt.fb_num[W-1:32] = pwdata[7:0];
        dsc_pkg::A_FBDEN_LO: st_nxt.fb_den[31:0] = pwdata;
        dsc_pkg::A_FBDEN_HI: st_nxt.fb_den[W-1:32] = pwdata[7:0];
        dsc_pkg::A_FREE_LO, dsc_pkg::A_FREE_HI: begin
          st_nxt.free_word = free_new;
          // A new word restarts the relative feed; leftover steps drop
          if (hist_en) begin
            st_nxt.ramp_rem  = free_new;
            st_nxt.ramp_cnt  = '0;
            st_nxt.ramp_done = 1'b0;
          end
        end
        dsc_pkg::A_ANUM_LO:  st_nxt.apll_num[31:0] = pwdata;
        dsc_pkg::A_ANUM_HI:  st_nxt.apll_num[W-1:32] = pwdata[7:0];
        dsc_pkg::A_RAMP:     st_nxt.ramp_cfg = pwdata;
        default: ;
      endcase
    end
    // Relative analog feed, only while the loop is open
    if (st_r.ramp_rem != '0 && !closed) begin
      if (st_r.ramp_cnt + 16'd1 >= st_r.ramp_cfg[31:dsc_pkg::R_PER_LSB]) begin
        st_nxt.ramp_cnt = '0;
        st_nxt.apll_off = st_r.apll_off + delta;
        st_nxt.ramp_rem = st_r.ramp_rem - delta;
        st_nxt.ramp_done = (st_r.ramp_rem == delta);
      end else begin
        st_nxt.ramp_cnt = st_r.ramp_cnt + 16'd1;
      end
    end
    // DCO steering; enable is taken only once locked
    if (!st_r.ctrl[dsc_pkg::C_STEER_EN]) begin
      st_nxt.steer_on = 1'b0;
      st_nxt.dpll_off = '0;
    end else if (st_r.mode == dsc_pkg::ST_LOCKED) begin
      st_nxt.steer_on = 1'b1;
    end
    if (step_go && st_r.steer_on && st_r.ctrl[dsc_pkg::C_STEER_EN]) begin
      if (closed) begin
        st_nxt.dpll_off = step_dn ? st_r.dpll_off - step_ext :
                                    st_r.dpll_off + step_ext;
      end else begin
        st_nxt.apll_off = step_dn ? st_nxt.apll_off - step_ext :
                                    st_nxt.apll_off + step_ext;
      end
    end
    // Operating state sequence
    unique case (st_r.mode)
      dsc_pkg::ST_CAL: begin
        if (!st_r.cal_req && det.xo_valid) begin
          st_nxt.cal_start = 1'b1;
          st_nxt.cal_req   = 1'b1;
        end else if (st_r.cal_req && det.cal_done) begin
          st_nxt.mode = dsc_pkg::ST_FREERUN;
        end
      end
      dsc_pkg::ST_FREERUN, dsc_pkg::ST_HOLD: begin
        if (any_ref) begin
          st_nxt.mode = dsc_pkg::ST_ACQ;
        end
      end
      dsc_pkg::ST_ACQ, dsc_pkg::ST_LOCKED: begin
        if (!any_ref) begin
          st_nxt.mode = hold_ok ? dsc_pkg::ST_HOLD :
                                  dsc_pkg::ST_FREERUN;
        end else if (st_r.mode == dsc_pkg::ST_ACQ &&
                     det.acq_done && det.freq_lock) begin
          st_nxt.mode = dsc_pkg::ST_LOCKED;
        end
      end
    endcase
    // Soft resets restart calibration; device reset also restores ctrl and ramp_cfg, clears offsets
    if (rst_wr) begin
      st_nxt.mode     = dsc_pkg::ST_CAL;
      st_nxt.cal_req  = 1'b0;
      st_nxt.steer_on = 1'b0;
      if (pwdata[dsc_pkg::C_DEV_RST]) begin
        st_nxt.ctrl     = dsc_pkg::CTRL_RST;
        st_nxt.ramp_cfg = dsc_pkg::RAMP_RST;
        st_nxt.dpll_off = '0;
        st_nxt.apll_off = '0;
        st_nxt.ramp_rem = '0;
      end
    end
    // Lock flags; frequency flag frozen through holdover
    unique case (st_nxt.mode)
      dsc_pkg::ST_ACQ, dsc_pkg::ST_LOCKED: begin
        st_nxt.fll = ~det.freq_lock;
        st_nxt.pll = ~det.phase_lock;
      end
      dsc_pkg::ST_HOLD: begin
        st_nxt.pll = 1'b1;
      end
      default: begin
        st_nxt.fll = 1'b1;
        st_nxt.pll = 1'b1;
      end
    endcase
    st_nxt.stat_pin[0] = stat_mux(st_r.ctrl[dsc_pkg::C_ST0_LSB +: 2],
        st_nxt.fll, st_nxt.pll, hacc, st_nxt.ramp_done);
    st_nxt.stat_pin[1] = stat_mux(st_r.ctrl[dsc_pkg::C_ST1_LSB +: 2],
        st_nxt.fll, st_nxt.pll, hacc, st_nxt.ramp_done);
    // Effective digital numerator
    if (closed) begin
      st_nxt.dnum = st_r.fb_num + st_r.dpll_off;
    end else if (st_r.mode == dsc_pkg::ST_HOLD && !(hist_en &&
                 det.hist_valid)) begin
      st_nxt.dnum = st_r.fb_num + st_r.free_word;
    end else begin
      st_nxt.dnum = st_r.fb_num;
    end
    // Effective analog numerator: direct or relative offset
    st_nxt.anum = hist_en ? st_r.apll_num + st_r.apll_off :
                  st_r.apll_num + st_r.free_word + st_r.apll_off;
    // Read data captured in the setup cycle
    if (rd_setup) begin
      unique case (paddr)
        dsc_pkg::A_CTRL:     st_nxt.rdata = st_r.ctrl;
        dsc_pkg::A_SWORD_LO: st_nxt.rdata = st_r.step_word[31:0];
        dsc_pkg::A_SWORD_HI: st_nxt.rdata = {26'd0, st_r.step_word[37:32]};
        dsc_pkg::A_FBNUM_LO: st_nxt.rdata = st_r.fb_num[31:0];
        dsc_pkg::A_FBNUM_HI: st_nxt.rdata = {24'd0, st_r.fb_num[W-1:32]};
        dsc_pkg::A_FBDEN_LO: st_nxt.rdata = st_r.fb_den[31:0];
        dsc_pkg::A_FBDEN_HI: st_nxt.rdata = {24'd0, st_r.fb_den[W-1:32]};
        dsc_pkg::A_FREE_LO:  st_nxt.rdata = st_r.free_word[31:0];
        dsc_pkg::A_FREE_HI:  st_nxt.rdata = {24'd0, st_r.free_word[W-1:32]};
        dsc_pkg::A_ANUM_LO:  st_nxt.rdata = st_r.apll_num[31:0];
        dsc_pkg::A_ANUM_HI:  st_nxt.rdata = {24'd0, st_r.apll_num[W-1:32]};
        dsc_pkg::A_RAMP:     st_nxt.rdata = st_r.ramp_cfg;
        dsc_pkg::A_STATUS:   st_nxt.rdata = {23'd0, st_r.cal_req,
            st_r.steer_on, st_r.ramp_done, hacc, st_r.pll, st_r.fll,
            st_r.mode};
        dsc_pkg::A_DEFF_LO:  st_nxt.rdata = st_r.dnum[31:0];
        dsc_pkg::A_DEFF_HI:  st_nxt.rdata = {24'd0, st_r.dnum[W-1:32]};
        dsc_pkg::A_AEFF_LO:  st_nxt.rdata = st_r.anum[31:0];
        dsc_pkg::A_AEFF_HI:  st_nxt.rdata = {24'd0, st_r.anum[W-1:32]};
        default:             st_nxt.rdata = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r          <= '0;
      st_r.ctrl     <= dsc_pkg::CTRL_RST;
      st_r.ramp_cfg <= dsc_pkg::RAMP_RST;
      st_r.fll      <= 1'b1;
      st_r.pll      <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign mode                 = st_r.mode;
  assign ref_qualified        = (st_r.mode == dsc_pkg::ST_FREERUN ||
                                 st_r.mode == dsc_pkg::ST_CAL) ?
                                '0 : ref_valid;
  assign wide_bw              = st_r.ctrl[dsc_pkg::C_FAST] &
                                (st_r.mode == dsc_pkg::ST_ACQ);
  assign freq_lock_loss_flag  = st_r.fll;
  assign phase_lock_loss_flag = st_r.pll;
  assign status_pin           = st_r.stat_pin;
  assign hist_accum_en        = hacc;
  assign use_history          = hist_en & det.hist_valid;
  assign holdover_offset_word = st_r.free_word;
  assign dpll_num_eff         = st_r.dnum;
  assign dpll_den_eff         = (st_r.fb_den == '0) ? {1'b1, {W{1'b0}}} :
                                {1'b0, st_r.fb_den};
  assign effective_analog_numerator = st_r.anum;
  assign vco_cal_start        = st_r.cal_start;
  assign steer_active         = st_r.steer_on;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_freerun_unqual: assert property (st_r.mode == dsc_pkg::ST_FREERUN
      |-> ref_qualified == '0) else $error("qualified in free-run");
  a_ref_starts_acq: assert property (
      (st_r.mode == dsc_pkg::ST_FREERUN || st_r.mode == dsc_pkg::ST_HOLD)
      && any_ref && !rst_wr |=> st_r.mode == dsc_pkg::ST_ACQ)
      else $error("no acquisition");
  a_lost_no_hist: assert property (
      st_r.mode == dsc_pkg::ST_LOCKED && !any_ref && !hold_ok && !rst_wr
      |=> st_r.mode == dsc_pkg::ST_FREERUN) else $error("not free-run");
  a_hold_entry: assert property (
      st_r.mode == dsc_pkg::ST_LOCKED && !any_ref && hold_ok && !rst_wr
      |=> st_r.mode == dsc_pkg::ST_HOLD && st_r.pll)
      else $error("bad holdover entry");
  a_fll_frozen: assert property (
      st_r.mode == dsc_pkg::ST_HOLD ##1 st_r.mode == dsc_pkg::ST_HOLD
      |-> $stable(st_r.fll)) else $error("frequency flag moved in holdover");
  a_locked_narrow: assert property (st_r.mode == dsc_pkg::ST_LOCKED
      |-> !wide_bw) else $error("wide bandwidth while locked");
  a_step_up: assert property (step_go && closed && st_r.steer_on &&
      st_r.ctrl[dsc_pkg::C_STEER_EN] && !step_dn && !rst_wr
      |=> st_r.dpll_off == $past(st_r.dpll_off) + $past(step_ext)) else
      $error("step up wrong");
  a_step_down: assert property (sw_step && pwdata[0] && closed &&
      st_r.steer_on && st_r.ctrl[dsc_pkg::C_STEER_EN] && !rst_wr
      |=> st_r.dpll_off == $past(st_r.dpll_off) - $past(step_ext)) else
      $error("step down wrong");
  a_steer_clear: assert property (
      !st_r.ctrl[dsc_pkg::C_STEER_EN]
      |=> st_r.dpll_off == '0 && !st_r.steer_on) else $error("offset kept");
  a_cal_rerun: assert property (
      rst_wr |=> st_r.mode == dsc_pkg::ST_CAL
      ##1 (!st_r.cal_req || st_r.cal_start)) else $error("no restart");
  a_pin_step: assert property (st_r.ctrl[dsc_pkg::C_PINMODE] &&
      trig_rise && !sw_step && closed && st_r.steer_on &&
      st_r.ctrl[dsc_pkg::C_STEER_EN] && !rst_wr
      |=> st_r.dpll_off == ($past(pin_dir) ?
      $past(st_r.dpll_off) - $past(step_ext) :
      $past(st_r.dpll_off) + $past(step_ext))) else $error("pin step lost");

  c_locked: cover property (st_r.mode == dsc_pkg::ST_ACQ ##1
      st_r.mode == dsc_pkg::ST_LOCKED);
  c_holdover: cover property (st_r.mode == dsc_pkg::ST_LOCKED ##1
      st_r.mode == dsc_pkg::ST_HOLD);
  c_ramp_done: cover property ($rose(st_r.ramp_done));
  c_pin_step: cover property (step_go && !sw_step && st_r.steer_on);
endmodule

// ===== dsc_pkg.sv
// Purpose: Shared constants and types for the DPLL state and DCO control
// Assumes: APB register map with one 32-bit word per register
// Notes:   40-bit quantities are split into low and high words
package dsc_pkg;
  // Sizes
  localparam int GPIO_N = 4;
  localparam int GPIO_W = 2;
  localparam int NUM_W  = 40;
  localparam int STEP_W = 38;
  // Register byte offsets
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_STEP     = 8'h04;
  localparam logic [7:0] A_SWORD_LO = 8'h08;
  localparam logic [7:0] A_SWORD_HI = 8'h0C;
  localparam logic [7:0] A_FBNUM_LO = 8'h10;
  localparam logic [7:0] A_FBNUM_HI = 8'h14;
  localparam logic [7:0] A_FBDEN_LO = 8'h18;
  localparam logic [7:0] A_FBDEN_HI = 8'h1C;
  localparam logic [7:0] A_FREE_LO  = 8'h20;
  localparam logic [7:0] A_FREE_HI  = 8'h24;
  localparam logic [7:0] A_ANUM_LO  = 8'h28;
  localparam logic [7:0] A_ANUM_HI  = 8'h2C;
  localparam logic [7:0] A_RAMP     = 8'h30;
  localparam logic [7:0] A_STATUS   = 8'h34;
  localparam logic [7:0] A_DEFF_LO  = 8'h38;
  localparam logic [7:0] A_DEFF_HI  = 8'h3C;
  localparam logic [7:0] A_AEFF_LO  = 8'h40;
  localparam logic [7:0] A_AEFF_HI  = 8'h44;
  // Control and ramp register fields
  localparam int C_STEER_EN = 0;
  localparam int C_HIST_EN  = 1;
  localparam int C_FAST     = 2;
  localparam int C_PINMODE  = 3;
  localparam int C_DEV_RST  = 4;
  localparam int C_PLL_RST  = 5;
  localparam int C_TRIG_LSB = 8;
  localparam int C_DIR_LSB  = 12;
  localparam int C_ST0_LSB  = 16;
  localparam int C_ST1_LSB  = 20;
  localparam int R_PER_LSB  = 16;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0004;
  localparam logic [31:0] RAMP_RST = 32'h0001_0001;
  // Timing
  localparam int CLK_NS       = 100;
  localparam int PULSE_MIN_NS = 100;
  localparam int PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {
    ST_CAL, ST_FREERUN, ST_ACQ, ST_LOCKED, ST_HOLD
  } dsc_mode_t;

  // Detector and start-up status from the analog side
  typedef struct packed {
    logic xo_valid;
    logic cal_done;
    logic acq_done;
    logic freq_lock;
    logic phase_lock;
    logic hist_valid;
  } dsc_det_t;

  typedef struct packed {
    dsc_mode_t          mode;
    logic               cal_req;
    logic               cal_start;
    logic [31:0]        ctrl;
    logic [STEP_W-1:0]  step_word;
    logic [NUM_W-1:0]   fb_num;
    logic [NUM_W-1:0]   fb_den;
    logic [NUM_W-1:0]   free_word;
    logic [NUM_W-1:0]   apll_num;
    logic [31:0]        ramp_cfg;
    logic [NUM_W-1:0]   dpll_off;
    logic [NUM_W-1:0]   apll_off;
    logic [NUM_W-1:0]   ramp_rem;
    logic [15:0]        ramp_cnt;
    logic               ramp_done;
    logic               steer_on;
    logic               fll;
    logic               pll;
    logic [GPIO_N-1:0]  s1;
    logic [GPIO_N-1:0]  s2;
    logic [GPIO_N-1:0]  s3;
    logic [GPIO_N-1:0]  lvl;
    logic [NUM_W-1:0]   dnum;
    logic [NUM_W-1:0]   anum;
    logic [1:0]         stat_pin;
    logic [31:0]        rdata;
  } dsc_state_t;
endpackage

// ===== dsc_ref_model.sv
// Purpose: Behavioural crystal, calibration and reference side
// Assumes: Same clock domain as the control block
// Notes:   Lock arrives a fixed few cycles after tracking; history after 40 cycles of accumulation
`timescale 1ns/1ns
module dsc_ref_model (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               ref_on,
  input  wire dsc_pkg::dsc_mode_t mode,
  input  wire logic               vco_cal_start,
  input  wire logic               hist_accum_en,
  output dsc_pkg::dsc_det_t       det,
  output logic [1:0]              ref_valid
);
  logic [7:0] xo_cnt;
  logic [7:0] cal_cnt;
  logic [7:0] lk_cnt;
  logic [7:0] hist_cnt;
  logic       trk;
  // Detectors only see lock while a reference is present and tracked
  assign trk = ref_on && (mode == dsc_pkg::ST_ACQ
                          || mode == dsc_pkg::ST_LOCKED);
  // Second input never qualifies
  assign ref_valid = {1'h0, ref_on};
  // Settle, calibration, lock and history timers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xo_cnt   <= 8'h00;
      cal_cnt  <= 8'h00;
      lk_cnt   <= 8'h00;
      hist_cnt <= 8'h00;
    end else begin
      xo_cnt   <= (xo_cnt < 8'h03) ? xo_cnt + 8'h01 : xo_cnt;
      cal_cnt  <= vco_cal_start ? 8'h01 :
                  (cal_cnt != 8'h00 && cal_cnt < 8'h05) ? cal_cnt + 8'h01
                                                         : cal_cnt;
      lk_cnt   <= !trk ? 8'h00 : (lk_cnt < 8'h0A) ? lk_cnt + 8'h01 : lk_cnt;
      hist_cnt <= !trk ? 8'h00 : (hist_accum_en && hist_cnt < 8'h28)
                                 ? hist_cnt + 8'h01 : hist_cnt;
    end
  end
  // Status levels seen by the control block, in field order
  assign det = {xo_cnt == 8'h03, cal_cnt == 8'h05, lk_cnt >= 8'h08,
                lk_cnt >= 8'h05, lk_cnt >= 8'h08, hist_cnt == 8'h28};
endmodule

// ===== dsc_ctrl_bench.sv
// Purpose: Self-checking bench for DPLL states and numerator steering
// Assumes: APB slave answers with no wait states
// Notes:   Reference side comes from the behavioural model
`timescale 1ns/1ns
module dsc_ctrl_bench;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic               ref_on, wide_bw, fll, pll, hacc, cal_st, st_act, perr;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic [3:0]         gpio_in;
  logic [1:0]         ref_valid, ref_q, stat;
  logic [40:0]        den;
  logic [39:0]        dnum, anum;
  dsc_pkg::dsc_det_t  det;
  dsc_pkg::dsc_mode_t mode;
  int                 err_count, cmp_count, cal_seen;
  localparam logic [39:0] FB = 40'h00_0010_0000;
  localparam logic [39:0] SW = 40'h00_0000_1000;

  dsc_ctrl #(.NUM_REFS(2)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .det(det), .ref_valid(ref_valid), .gpio_in(gpio_in), .mode(mode),
    .ref_qualified(ref_q), .wide_bw(wide_bw), .freq_lock_loss_flag(fll),
    .phase_lock_loss_flag(pll), .status_pin(stat), .hist_accum_en(hacc),
    .use_history(), .holdover_offset_word(), .dpll_num_eff(dnum),
    .dpll_den_eff(den), .effective_analog_numerator(anum),
    .vco_cal_start(cal_st), .steer_active(st_act));
  dsc_ref_model ref_side (.pclk(pclk), .presetn(presetn), .ref_on(ref_on),
    .mode(mode), .vco_cal_start(cal_st), .hist_accum_en(hacc), .det(det),
    .ref_valid(ref_valid));

  // Clock and calibration pulse count
  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) if (cal_st === 1'h1) cal_seen++;

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; holds until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge pclk);
  endtask
  task automatic step(input logic dn);
    apb(1'h1, dsc_pkg::A_STEP, {31'h0000_0000, dn});
    tick(2);
  endtask
  task automatic wait_mode(input dsc_pkg::dsc_mode_t m);
    int n;
    n = 0;
    while (mode !== m && n < 300) begin
      @(negedge pclk);
      n++;
    end
    chk(mode, m);
  endtask
  task automatic set_ref(input logic v);
    @(posedge pclk);
    ref_on <= v;
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    close_out;
  end

  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, ref_on} = 5'h00;
    {paddr, pwdata, gpio_in} = 44'h000_0000_0000;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, dsc_pkg::A_CTRL, 32'h0000_0000);
    chk(rd, dsc_pkg::CTRL_RST);
    apb(1'h0, dsc_pkg::A_RAMP, 32'h0000_0000);
    chk(rd, dsc_pkg::RAMP_RST);
    wait_mode(dsc_pkg::ST_FREERUN);
    chk(ref_q, 2'h0);
    chk(den, 41'h100_0000_0000);
    set_ref(1'h1);
    wait_mode(dsc_pkg::ST_ACQ);
    chk({wide_bw, ref_q}, 3'h5);
    wait_mode(dsc_pkg::ST_LOCKED);
    chk({wide_bw, fll, pll}, 3'h0);
    apb(1'h1, dsc_pkg::A_CTRL, 32'h0000_0005);
    apb(1'h1, dsc_pkg::A_SWORD_LO, SW[31:0]);
    apb(1'h1, dsc_pkg::A_SWORD_HI, 32'h0000_0000);
    apb(1'h1, dsc_pkg::A_FBNUM_LO, FB[31:0]);
    apb(1'h1, dsc_pkg::A_FBNUM_HI, 32'h0000_0000);
    chk(st_act, 1'h1);
    step(1'h0);
    chk(dnum, FB + SW);
    step(1'h1);
    step(1'h1);
    chk(dnum, FB - SW);
    // Pin steps: trigger on pin 0, direction on pin 1, pulses two cycles
    apb(1'h1, dsc_pkg::A_CTRL, 32'h0000_100D);
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk);
      gpio_in <= {2'h0, i == 0, 1'h0};
      @(posedge pclk);
      gpio_in[0] <= 1'h1;
      repeat (2) @(posedge pclk);
      gpio_in[0] <= 1'h0;
      tick(8);
      chk(dnum, (i == 0) ? FB - 2 * SW : FB - SW);
    end
    apb(1'h1, dsc_pkg::A_CTRL, 32'h0000_0004);
    tick(3);
    chk(dnum, FB);
    apb(1'h1, dsc_pkg::A_CTRL, 32'h0000_0005);
    apb(1'h1, dsc_pkg::A_FREE_LO, 32'h0000_0200);
    apb(1'h1, dsc_pkg::A_FREE_HI, 32'h0000_0000);
    apb(1'h1, dsc_pkg::A_ANUM_LO, 32'h0000_8000);
    apb(1'h1, dsc_pkg::A_ANUM_HI, 32'h0000_0000);
    set_ref(1'h0);
    wait_mode(dsc_pkg::ST_HOLD);
    tick(2);
    chk({fll, pll}, 2'h1);
    chk(dnum, FB + 40'h00_0000_0200);
    apb(1'h0, dsc_pkg::A_AEFF_LO, 32'h0000_0000);
    chk(rd, 32'h0000_8200);
    step(1'h0);
    chk(anum, 40'h00_0000_9200);
    set_ref(1'h1);
    wait_mode(dsc_pkg::ST_ACQ);
    wait_mode(dsc_pkg::ST_LOCKED);
    apb(1'h1, dsc_pkg::A_CTRL, 32'h0000_0006);
    tick(1);
    chk(hacc, 1'h1);
    set_ref(1'h0);
    wait_mode(dsc_pkg::ST_FREERUN);
    apb(1'h0, 8'h48, 32'h0000_0000);
    chk({perr, rd}, {1'h1, 32'h0000_0000});
    apb(1'h1, dsc_pkg::A_CTRL, 32'h0000_0024);
    wait_mode(dsc_pkg::ST_CAL);
    wait_mode(dsc_pkg::ST_FREERUN);
    chk(cal_seen, 2);
    // Relative analog feed: three moves of 0x100, one per two cycles
    apb(1'h1, dsc_pkg::A_CTRL, 32'h0003_0006);
    apb(1'h1, dsc_pkg::A_RAMP, 32'h0002_0100);
    apb(1'h1, dsc_pkg::A_FREE_LO, 32'h0000_0300);
    tick(10);
    chk(anum, 40'h00_0000_9300);
    chk(stat, 2'h3);
    close_out;
  end
endmodule
